//--- logic/bridge_gate_pulse_generator.sv
// Gate pulse generator for an external P/N MOSFET full or half bridge.
// Assumes registers are written through a byte port from the serial interface logic,
// straps are static pins, and the clock is the multiplied pulse time base.
`timescale 1ns/100ps
`default_nettype none
`include "bridge_gate_regs.svh"

// Function
// (RULE_01) Reference clock must be 8 MHz
// (RULE_02) Clock source strap selects on-chip oscillator
// (RULE_03) Topology strap low full, high half
// (RULE_04) Half bridge: leg B high-off, low-off
// (RULE_05) Period is 11-bit count of base
// (RULE_06) On-time 10-bit count, duty at most half
// (RULE_07) Four 5-bit dead-time counts per leg; the code has two per leg, four in all
// (RULE_08) Modulation step widens on-time during packet
// (RULE_09) On-time limit 10-bit, at most half
// (RULE_10) Leg A sums stay below half, limit
// (RULE_11) Leg B sums stay below half, limit
// (RULE_12) Soft start ramps on-time toward target
// (RULE_13) Pulses only in drive state
// (RULE_14) High sides active low, never shoot-through
// (RULE_15) New timing taken at period boundary
module bridge_gate_pulse_generator
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_source_strap,
    input wire logic topology_strap,
    input wire logic configDone,
    input wire logic commActive,
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWriteData,
    output logic [7:0] regReadData,
    output logic onChipClockSelect,
    output logic halfBridgeMode,
    output logic driving,
    output logic leg_a_high_gate,
    output logic leg_a_low_gate,
    output logic leg_b_high_gate,
    output logic leg_b_low_gate
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------

    // Half-open window test on the period count
    function automatic logic inWindow(input logic [11:0] count, input logic [11:0] start, input logic [11:0] len);
        logic [12:0] stop;
        stop = {1'b0, start} + {1'b0, len};
        inWindow = ({1'b0, count} >= {1'b0, start}) && ({1'b0, count} < stop);
    endfunction

    // ----------------------------------------
    // Strap synchronisers
    // ----------------------------------------

    logic [1:0] clkStrapSync;
    logic [1:0] topoStrapSync;
    logic [1:0] next_clkStrapSync;
    logic [1:0] next_topoStrapSync;

    // Straps are pins, so two flops before use
    always_comb
    begin
        next_clkStrapSync = {clkStrapSync[0], clock_source_strap};
        next_topoStrapSync = {topoStrapSync[0], topology_strap};
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clkStrapSync <= 2'h0;
            topoStrapSync <= 2'h0;
        end
        else
        begin
            clkStrapSync <= next_clkStrapSync;
            topoStrapSync <= next_topoStrapSync;
        end
    end

    assign onChipClockSelect = clkStrapSync[1]; // [RULE_02]

    // ----------------------------------------
    // Register file
    // ----------------------------------------

    bridge_gate_pkg::timing_t regs;
    bridge_gate_pkg::timing_t next_regs;
    logic [7:0] next_regReadData;

    // Byte writes into split fields; upper unused bits dropped
    always_comb
    begin
        next_regs = regs;
        if (regWrite)
        begin
            case (regAddr)
                `ADDR_DRIVE_PERIOD_LOW: next_regs.period[7:0] = regWriteData; // [RULE_05]
                `ADDR_DRIVE_PERIOD_HIGH: next_regs.period[10:8] = regWriteData[2:0];
                `ADDR_ON_TIME_LOW: next_regs.onTime[7:0] = regWriteData; // [RULE_06]
                `ADDR_ON_TIME_HIGH: next_regs.onTime[9:8] = regWriteData[1:0];
                `ADDR_LEG_A_DEAD_FIRST: next_regs.legADeadFirst = regWriteData[4:0]; // [RULE_07]
                `ADDR_LEG_A_DEAD_SECOND: next_regs.legADeadSecond = regWriteData[4:0];
                `ADDR_LEG_B_DEAD_FIRST: next_regs.legBDeadFirst = regWriteData[4:0];
                `ADDR_LEG_B_DEAD_SECOND: next_regs.legBDeadSecond = regWriteData[4:0];
                `ADDR_MOD_STEP: next_regs.modStep = regWriteData[6:0]; // [RULE_08]
                `ADDR_ON_LIMIT_LOW: next_regs.onLimit[7:0] = regWriteData; // [RULE_09]
                `ADDR_ON_LIMIT_HIGH: next_regs.onLimit[9:8] = regWriteData[1:0];
                default: next_regs = regs;
            endcase
        end
    end

    // Read mux; unmapped offsets and unused bits read zero
    always_comb
    begin
        case (regAddr)
            `ADDR_DRIVE_PERIOD_LOW: next_regReadData = regs.period[7:0];
            `ADDR_DRIVE_PERIOD_HIGH: next_regReadData = {5'h00, regs.period[10:8]};
            `ADDR_ON_TIME_LOW: next_regReadData = regs.onTime[7:0];
            `ADDR_ON_TIME_HIGH: next_regReadData = {6'h00, regs.onTime[9:8]};
            `ADDR_LEG_A_DEAD_FIRST: next_regReadData = {3'h0, regs.legADeadFirst};
            `ADDR_LEG_A_DEAD_SECOND: next_regReadData = {3'h0, regs.legADeadSecond};
            `ADDR_LEG_B_DEAD_FIRST: next_regReadData = {3'h0, regs.legBDeadFirst};
            `ADDR_LEG_B_DEAD_SECOND: next_regReadData = {3'h0, regs.legBDeadSecond};
            `ADDR_MOD_STEP: next_regReadData = {1'h0, regs.modStep};
            `ADDR_ON_LIMIT_LOW: next_regReadData = regs.onLimit[7:0];
            `ADDR_ON_LIMIT_HIGH: next_regReadData = {6'h00, regs.onLimit[9:8]};
            default: next_regReadData = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            regs <= '{`RESET_PERIOD, `RESET_ON_TIME, `RESET_DEAD, `RESET_DEAD, `RESET_DEAD, `RESET_DEAD,
                      `RESET_MOD, `RESET_ON_LIMIT};
            regReadData <= 8'h00;
        end
        else
        begin
            regs <= next_regs;
            regReadData <= next_regReadData;
        end
    end

    // ----------------------------------------
    // Period engine, soft start and gates
    // ----------------------------------------

    bridge_gate_pkg::drive_state_t state;
    bridge_gate_pkg::drive_state_t next_state;
    bridge_gate_pkg::timing_t shadow;
    bridge_gate_pkg::timing_t next_shadow;
    bridge_gate_pkg::gates_t gates;
    bridge_gate_pkg::gates_t next_gates;
    logic [10:0] count;
    logic [10:0] next_count;
    logic [9:0] rampOnTime;
    logic [9:0] next_rampOnTime;
    logic halfMode;
    logic next_halfMode;
    logic boundary;
    logic [11:0] pulseLen;
    logic [11:0] halfPeriod;
    logic [11:0] limitLen;
    logic [11:0] cnt12;
    logic aHighOn;
    logic bLowOn;

    // Period of one count wraps on the last count
    assign boundary = (count >= shadow.period - 11'h001) || (shadow.period == 11'h000);
    assign cnt12 = {1'b0, count};
    assign halfPeriod = {2'h0, shadow.period[10:1]};
    assign limitLen = {2'h0, shadow.onLimit};

    // Pulse length: ramped on-time plus step while sending, clipped to the limit
    always_comb
    begin
        pulseLen = {2'h0, rampOnTime} + (commActive ? {5'h00, shadow.modStep} : 12'h000); // [RULE_08]
        if (pulseLen > limitLen)
        begin
            pulseLen = limitLen; // [RULE_09]
        end
    end

    // State, counter, shadow latch and soft start
    always_comb
    begin
        next_state = state;
        next_count = count;
        next_shadow = shadow;
        next_rampOnTime = rampOnTime;
        next_halfMode = halfMode;
        case (state)
            bridge_gate_pkg::STATE_INITIAL:
            begin
                next_count = 11'h000;
                next_rampOnTime = 10'h000;
                next_shadow = regs;
                next_halfMode = topoStrapSync[1];
                if (configDone)
                begin
                    next_state = bridge_gate_pkg::STATE_DRIVE; // [RULE_13]
                end
            end
            bridge_gate_pkg::STATE_DRIVE:
            begin
                next_count = boundary ? 11'h000 : count + 11'h001; // [RULE_05]
                if (!configDone)
                begin
                    next_state = bridge_gate_pkg::STATE_INITIAL;
                end
                else if (boundary)
                begin
                    next_shadow = regs; // [RULE_15]
                    next_halfMode = topoStrapSync[1];
                    // One step per period keeps bridge current change gentle
                    if (rampOnTime < shadow.onTime)
                    begin
                        next_rampOnTime = rampOnTime + `RAMP_STEP; // [RULE_12]
                    end
                    else if (rampOnTime > shadow.onTime)
                    begin
                        next_rampOnTime = rampOnTime - `RAMP_STEP; // [RULE_12]
                    end
                end
            end
            default:
            begin
                next_state = bridge_gate_pkg::STATE_INITIAL;
            end
        endcase
    end

    // Gate windows; first half conducts leg A high with leg B low, second half the reverse
    always_comb
    begin
        aHighOn = inWindow(cnt12, {7'h00, shadow.legADeadFirst}, pulseLen); // [RULE_07]
        bLowOn = inWindow(cnt12, {7'h00, shadow.legBDeadFirst}, pulseLen);
        next_gates.legAHigh = 1'b1;
        next_gates.legALow = 1'b0;
        next_gates.legBHigh = 1'b1;
        next_gates.legBLow = 1'b0;
        if ((state == bridge_gate_pkg::STATE_DRIVE) && !boundary) // [RULE_13]
        begin
            next_gates.legAHigh = !aHighOn; // [RULE_14]
            // Interlock guards against a bad setting causing shoot-through
            next_gates.legALow = inWindow(cnt12, halfPeriod + {7'h00, shadow.legADeadSecond}, pulseLen) && !aHighOn;
            if (!halfMode) // [RULE_03]
            begin
                next_gates.legBLow = bLowOn;
                next_gates.legBHigh = !(inWindow(cnt12, halfPeriod + {7'h00, shadow.legBDeadSecond}, pulseLen)
                                        && !bLowOn); // [RULE_14]
            end
            // Half bridge leaves leg B parked off [RULE_04]
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= bridge_gate_pkg::STATE_INITIAL;
            count <= 11'h000;
            shadow <= '{`RESET_PERIOD, `RESET_ON_TIME, `RESET_DEAD, `RESET_DEAD, `RESET_DEAD, `RESET_DEAD,
                        `RESET_MOD, `RESET_ON_LIMIT};
            rampOnTime <= 10'h000;
            halfMode <= 1'b0;
            gates <= 4'b1010;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            shadow <= next_shadow;
            rampOnTime <= next_rampOnTime;
            halfMode <= next_halfMode;
            gates <= next_gates;
        end
    end

    assign leg_a_high_gate = gates.legAHigh;
    assign leg_a_low_gate = gates.legALow;
    assign leg_b_high_gate = gates.legBHigh;
    assign leg_b_low_gate = gates.legBLow;
    assign halfBridgeMode = halfMode;
    assign driving = (state == bridge_gate_pkg::STATE_DRIVE);

endmodule

`default_nettype wire

//--- shared/bridge_gate_pkg.sv
// Types shared by the bridge gate pulse generator.
// Assumes bridge_gate_regs.svh supplies the field widths.
`include "bridge_gate_regs.svh"

package bridge_gate_pkg;

    // Operating state, one-hot
    typedef enum logic [1:0]
    {
        STATE_INITIAL = 2'b01,
        STATE_DRIVE = 2'b10
    } drive_state_t;

    // One set of pulse timing values
    typedef struct packed
    {
        logic [`PERIOD_WIDTH-1:0] period;
        logic [`ON_TIME_WIDTH-1:0] onTime;
        logic [`DEAD_WIDTH-1:0] legADeadFirst;
        logic [`DEAD_WIDTH-1:0] legADeadSecond;
        logic [`DEAD_WIDTH-1:0] legBDeadFirst;
        logic [`DEAD_WIDTH-1:0] legBDeadSecond;
        logic [`MOD_WIDTH-1:0] modStep;
        logic [`ON_TIME_WIDTH-1:0] onLimit;
    } timing_t;

    // Gate pin levels; high sides are active low
    typedef struct packed
    {
        logic legAHigh;
        logic legALow;
        logic legBHigh;
        logic legBLow;
    } gates_t;

endpackage

//--- shared/bridge_gate_regs.svh
// Register offsets, field layouts and reset values of the bridge gate pulse generator.
// Assumes byte-wide registers reached through the serial register port.
`ifndef BRIDGE_GATE_REGS_SVH
`define BRIDGE_GATE_REGS_SVH

`define ADDR_DRIVE_PERIOD_LOW 8'h04
`define ADDR_DRIVE_PERIOD_HIGH 8'h05
`define ADDR_ON_TIME_LOW 8'h06
`define ADDR_ON_TIME_HIGH 8'h07
`define ADDR_LEG_A_DEAD_FIRST 8'h09
`define ADDR_LEG_A_DEAD_SECOND 8'h0a
`define ADDR_LEG_B_DEAD_FIRST 8'h0b
`define ADDR_LEG_B_DEAD_SECOND 8'h0c
`define ADDR_MOD_STEP 8'h0d
`define ADDR_ON_LIMIT_LOW 8'h13
`define ADDR_ON_LIMIT_HIGH 8'h14

`define PERIOD_WIDTH 11
`define ON_TIME_WIDTH 10
`define DEAD_WIDTH 5
`define MOD_WIDTH 7

`define RESET_PERIOD 11'h400
`define RESET_ON_TIME 10'h000
`define RESET_DEAD 5'h00
`define RESET_MOD 7'h00
`define RESET_ON_LIMIT 10'h000

// Soft start step, on-time counts per period
`define RAMP_STEP 10'h001

`endif

//--- verification/bridge_gate_chk.sv
// Port checker for the bridge gate pulse generator.
// Assumes one clock domain with async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module bridge_gate_chk
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_source_strap,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regReadData,
    input wire logic onChipClockSelect,
    input wire logic halfBridgeMode,
    input wire logic driving,
    input wire logic leg_a_high_gate,
    input wire logic leg_a_low_gate,
    input wire logic leg_b_high_gate,
    input wire logic leg_b_low_gate
);
    // All checks sample on the time base, idle in reset
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    // Both switches of one leg on is a dead short
    chk_a_overlap: assert property (!(!leg_a_high_gate && leg_a_low_gate))
        else $error("leg A both on");
    chk_b_overlap: assert property (!(!leg_b_high_gate && leg_b_low_gate))
        else $error("leg B both on");
    // Mode flop leads the gates by one cycle, hence the past term
    chk_half_idle: assert property (halfBridgeMode && $past(halfBridgeMode) |->
        leg_b_high_gate && !leg_b_low_gate)
        else $error("leg B pulsed in half mode");
    chk_stop_idle: assert property (!driving && !$past(driving) |->
        leg_a_high_gate && !leg_a_low_gate && leg_b_high_gate && !leg_b_low_gate)
        else $error("gates on outside drive");
    chk_start_quiet: assert property ($rose(driving) |-> leg_a_high_gate [*4])
        else $error("full pulse at drive start");
    chk_sync_high: assert property (clock_source_strap [*3] |-> onChipClockSelect)
        else $error("oscillator select late");
    chk_sync_low: assert property ((!clock_source_strap) [*3] |-> !onChipClockSelect)
        else $error("oscillator select stuck");
    chk_period_bits: assert property ((regAddr == 8'h05) [*2] |-> regReadData[7:3] == 5'h00)
        else $error("period high reads spare bits");
endmodule
// Attach to every generator instance
bind bridge_gate_pulse_generator bridge_gate_chk chk
(
    .clock(clock), .reset_n(reset_n), .clock_source_strap(clock_source_strap),
    .regAddr(regAddr), .regReadData(regReadData), .onChipClockSelect(onChipClockSelect),
    .halfBridgeMode(halfBridgeMode), .driving(driving),
    .leg_a_high_gate(leg_a_high_gate), .leg_a_low_gate(leg_a_low_gate),
    .leg_b_high_gate(leg_b_high_gate), .leg_b_low_gate(leg_b_low_gate)
);
`default_nettype wire

//--- verification/bridge_model.sv
// Behavioural P/N MOSFET bridge seen from the gate pins.
// Assumes gate levels arrive as the package gate struct.
`timescale 1ns/100ps
`default_nettype none
module bridge_model
(
    input wire logic clock,
    input wire logic reset_n,
    input wire bridge_gate_pkg::gates_t gates,
    output logic fault
);
    logic next_fault;
    // Shoot-through latches; a real bridge would not recover
    always_comb
    begin
        next_fault = fault;
        if (!gates.legAHigh && gates.legALow)
            next_fault = 1'b1;
        if (!gates.legBHigh && gates.legBLow)
            next_fault = 1'b1;
    end
    // Fault flag register
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            fault <= 1'b0;
        else
            fault <= next_fault;
    end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the bridge gate pulse generator.
// Assumes design, bridge model and checker compile first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic clock_source_strap = 1'b0;
    logic topology_strap = 1'b0;
    logic configDone = 1'b0;
    logic commActive = 1'b0;
    logic regWrite = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWriteData = 8'h00;
    logic [7:0] regReadData;
    logic onChipClockSelect;
    logic halfBridgeMode;
    logic driving;
    logic fault;
    wire bridge_gate_pkg::gates_t gates;
    logic [31:0] seed = 32'h6ac2;
    int bad_count = 0;
    int total_checks = 0;
    int width = 0;
    int expq[$];
    logic [7:0] regA [8] = '{8'h05, 8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h14};
    logic [7:0] regM [8] = '{8'h07, 8'h03, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h7f, 8'h03};
    logic [7:0] cfgA [11] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h13, 8'h14};
    logic [7:0] cfgD [11] = '{8'h20, 8'h00, 8'h04, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h02, 8'h0c, 8'h00};
    // Clock doubles as the pulse time base
    always #5 clock = ~clock;
    bridge_gate_pulse_generator uut
    (
        .clock(clock), .reset_n(reset_n), .clock_source_strap(clock_source_strap),
        .topology_strap(topology_strap), .configDone(configDone), .commActive(commActive),
        .regWrite(regWrite), .regAddr(regAddr), .regWriteData(regWriteData),
        .regReadData(regReadData), .onChipClockSelect(onChipClockSelect),
        .halfBridgeMode(halfBridgeMode), .driving(driving),
        .leg_a_high_gate(gates.legAHigh), .leg_a_low_gate(gates.legALow),
        .leg_b_high_gate(gates.legBHigh), .leg_b_low_gate(gates.legBLow)
    );
    bridge_model partner (.clock(clock), .reset_n(reset_n), .gates(gates), .fault(fault));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // One write strobe, then a free cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    // Read data is registered, so settle two edges
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        regAddr <= a;
        repeat (2) @(posedge clock);
        #1 check(32'(regReadData), 32'(e));
    endtask
    // Bounded wait for all noted pulse widths
    task automatic waitq(input string s);
        int i;
        for (i = 0; i < 2000 && expq.size() > 0; i++)
            @(posedge clock);
        if (expq.size() > 0)
        begin
            bad_count++;
            summarize();
        end
        $display("test %s done", s);
    endtask
    // Leg A on-time measured at its trailing edge
    always @(negedge clock)
    begin
        // Equal leg dead times make the diagonal switches move together
        if (driving === 1'b1 && halfBridgeMode === 1'b0)
        begin
            check(32'(gates.legBLow), 32'(!gates.legAHigh));
            check(32'(!gates.legBHigh), 32'(gates.legALow));
        end
        if (gates.legAHigh === 1'b0)
            width <= width + 1;
        else if (width != 0)
        begin
            if (expq.size() > 0)
                check(width, expq.pop_front());
            width <= 0;
        end
    end
    initial
    begin
        int i;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        rd(8'h05, 8'h04);
        rd(8'h04, 8'h00);
        // Random bytes; spare bits must read back clear
        for (i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            wr(regA[i], seed[7:0]);
            rd(regA[i], seed[7:0] & regM[i]);
        end
        wr(8'h08, seed[15:8]);
        rd(8'h08, 8'h00);
        // Period 32, on 4, dead 1, step 2, limit 12: sums stay legal
        for (i = 0; i < 11; i++)
            wr(cfgA[i], cfgD[i]);
        expq = '{1, 2, 3, 4, 4};
        configDone <= 1'b1;
        waitq("soft start");
        commActive <= 1'b1;
        expq = '{6, 6};
        waitq("modulation on");
        commActive <= 1'b0;
        expq = '{4};
        waitq("modulation off");
        // New target lands at the next boundary, then one count per period
        wr(8'h06, 8'h06);
        expq = '{4, 5, 6};
        waitq("on-time change");
        topology_strap <= 1'b1;
        clock_source_strap <= 1'b1;
        repeat (100) @(posedge clock);
        #1;
        check(32'(halfBridgeMode), 32'(1'b1));
        check(32'(onChipClockSelect), 32'(1'b1));
        check(32'({gates.legBHigh, gates.legBLow}), 32'(2'b10));
        expq = '{6};
        waitq("half bridge");
        configDone <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        check(32'(driving), 32'(1'b0));
        check(32'(gates), 32'(4'b1010));
        check(32'(fault), 32'(1'b0));
        $display("test stop done");
        summarize();
    end
endmodule
`default_nettype wire
